// >>> inc/totalizer_defines.svh
`ifndef TOTALIZER_DEFINES_SVH
`define TOTALIZER_DEFINES_SVH
// ****************************************
// Register map
// ****************************************
`define ADDR_CONTROL      4'h0
`define ADDR_SETUP        4'h1
`define ADDR_START        4'h2
`define ADDR_COUNT        4'h3
`define CTRL_CLEAR_BIT    0
`define CTRL_LOAD_BIT     1
`define SETUP_DIR_BIT     0
`define SETUP_DEB_BIT     1
// ****************************************
// Reset values and timing
// ****************************************
`define COUNT_ZERO        32'h0000_0000
`define COUNT_MAX         32'hFFFF_FFFF
`define DEBOUNCE_NS       2000000
`define CLOCK_PERIOD_NS   25
`define DEBOUNCE_CYCLES   ((`DEBOUNCE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`endif

// >>> inc/totalizer_pkg.sv
package totalizer_pkg;
   typedef logic [31:0] count_t;
endpackage

// >>> rtl/event_totalizer_counter.sv
// Added by the designer: the address map and the address-and-strobe port.
`include "totalizer_defines.svh"
module event_totalizer_counter #(
   parameter int unsigned DEBOUNCE_LIMIT = `DEBOUNCE_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        clock_enable,
   input  wire logic        count_pin,
   input  wire logic        gating_control_line,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   output logic             count_up_mode,
   output logic             debounce_on
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [2:0]             cnt_sync;
      logic [2:0]             gate_sync;
      logic                   cnt_level;
      logic                   gate_level;
      logic                   filt_level;
      logic [31:0]            stable_cnt;
      logic                   dir;
      logic                   deb;
      totalizer_pkg::count_t  start;
      totalizer_pkg::count_t  count;
      logic [31:0]            rdata;
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic   src_level;
   logic   prev_level;
   logic   event_hit;

   // ****************************************
   // Helpers
   // ****************************************
   // Plain modulo arithmetic gives both wraps for free, so no end-of-range compare is needed
   function automatic totalizer_pkg::count_t step(input totalizer_pkg::count_t c, input logic up);
      if (up) begin
         step = c + 32'h0000_0001;
      end else begin
         step = c - 32'h0000_0001;
      end
   endfunction

   always_comb begin
      state_next = state_reg;
      // ****************************************
      // Input synchronisers
      // ****************************************
      // Three-stage synchroniser; stage 0 feeds only stage 1
      state_next.cnt_sync  = {state_reg.cnt_sync[1:0], count_pin};
      state_next.gate_sync = {state_reg.gate_sync[1:0], gating_control_line};
      if (state_reg.cnt_sync[1] == state_reg.cnt_sync[2]) begin
         state_next.cnt_level = state_reg.cnt_sync[2];
      end
      if (state_reg.gate_sync[1] == state_reg.gate_sync[2]) begin
         state_next.gate_level = state_reg.gate_sync[2];
      end
      // ****************************************
      // Debounce filter
      // ****************************************
      // Filter needs the level stable for the whole window; slow inputs pass late but whole
      if (state_reg.cnt_level == state_reg.filt_level) begin
         state_next.stable_cnt = 32'h0000_0000;
      end else if (state_reg.stable_cnt >= DEBOUNCE_LIMIT - 1) begin
         state_next.filt_level = state_reg.cnt_level;
         state_next.stable_cnt = 32'h0000_0000;
      end else begin
         state_next.stable_cnt = state_reg.stable_cnt + 32'h0000_0001;
      end
      // ****************************************
      // Edge detect and count
      // ****************************************
      src_level  = state_reg.deb ? state_reg.filt_level : state_reg.cnt_level;
      prev_level = state_reg.deb ? state_next.filt_level : state_next.cnt_level;
      // Rising edge of the chosen source, one count per input cycle
      event_hit  = prev_level & ~src_level;
      // Gate passes the same synchroniser depth as the count input; with debounce on, the count also waits out the filter window
      if (event_hit && !state_reg.gate_level) begin
         state_next.count = step(state_reg.count, state_reg.dir);
      end
      // ****************************************
      // Register port
      // ****************************************
      // Read data fall back to zero on every enabled cycle without a read; with clock_enable low they hold
      state_next.rdata = 32'h0000_0000;
      if (wr) begin
         case (addr)
            `ADDR_CONTROL: begin
               if (wdata[`CTRL_LOAD_BIT]) begin
                  state_next.count = state_reg.start;
               end
               if (wdata[`CTRL_CLEAR_BIT]) begin
                  state_next.count = `COUNT_ZERO;
               end
            end
            `ADDR_SETUP: begin
               state_next.dir = wdata[`SETUP_DIR_BIT];
               state_next.deb = wdata[`SETUP_DEB_BIT];
            end
            `ADDR_START: begin
               state_next.start = wdata;
            end
            default: begin
            end
         endcase
      end
      if (rd) begin
         case (addr)
            `ADDR_SETUP: state_next.rdata = {30'h0000_0000, state_reg.deb, state_reg.dir};
            `ADDR_START: state_next.rdata = state_reg.start;
            `ADDR_COUNT: state_next.rdata = state_reg.count;
            default:     state_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         // Gate starts held and the count idles up; nothing counts until the gate line is synchronised
         state_reg <= '0;
         state_reg.gate_sync <= 3'h7;
         state_reg.gate_level <= 1'b1;
         state_reg.dir <= 1'b1;
      end else if (clock_enable) begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata         = state_reg.rdata;
   assign count_up_mode = state_reg.dir;
   assign debounce_on   = state_reg.deb;

   // ****************************************
   // Checks
   // ****************************************
   // The count checks skip write cycles, since a control write with the clear or load bit overrides a same-cycle count event
   sequence clear_write;
      clock_enable && wr && addr == `ADDR_CONTROL && wdata[`CTRL_CLEAR_BIT];
   endsequence
   sequence open_event;
      clock_enable && !wr && event_hit && !state_reg.gate_level;
   endsequence
   sequence read_count;
      clock_enable && rd && addr == `ADDR_COUNT;
   endsequence
   sequence read_setup;
      clock_enable && rd && addr == `ADDR_SETUP;
   endsequence
   chk_clear_zero: assert property (@(posedge clock) disable iff (rst)
      clear_write |=> state_reg.count == `COUNT_ZERO)
      else $error("count not zero after clear");
   chk_down_wrap: assert property (@(posedge clock) disable iff (rst)
      open_event ##0 (!state_reg.dir && state_reg.count == `COUNT_ZERO) |=> state_reg.count == `COUNT_MAX)
      else $error("down count did not wrap");
   chk_up_wrap: assert property (@(posedge clock) disable iff (rst)
      open_event ##0 (state_reg.dir && state_reg.count == `COUNT_MAX) |=> state_reg.count == `COUNT_ZERO)
      else $error("up count did not wrap");
   chk_gate_hold: assert property (@(posedge clock) disable iff (rst)
      !wr && state_reg.gate_level |=> $stable(state_reg.count))
      else $error("count moved while gated");
   chk_gate_count: assert property (@(posedge clock) disable iff (rst)
      open_event ##0 state_reg.dir |=> state_reg.count == $past(state_reg.count) + 32'h0000_0001)
      else $error("enabled event not counted up");
   chk_down_step: assert property (@(posedge clock) disable iff (rst)
      open_event ##0 !state_reg.dir |=> state_reg.count == $past(state_reg.count) - 32'h0000_0001)
      else $error("enabled event not counted down");
   chk_no_event: assert property (@(posedge clock) disable iff (rst)
      !wr && !event_hit |=> $stable(state_reg.count))
      else $error("count moved without event");
   chk_filter_fast: assert property (@(posedge clock) disable iff (rst)
      clock_enable && state_reg.deb && state_reg.cnt_level != state_reg.filt_level
      && state_reg.stable_cnt == 32'h0000_0000 |=> state_reg.filt_level == $past(state_reg.filt_level))
      else $error("filter passed a short pulse");
   chk_filter_pass: assert property (@(posedge clock) disable iff (rst)
      clock_enable && state_reg.cnt_level != state_reg.filt_level && state_reg.stable_cnt == DEBOUNCE_LIMIT - 1
      |=> state_reg.filt_level == $past(state_reg.cnt_level))
      else $error("filter did not pass a held level");
   chk_start_load: assert property (@(posedge clock) disable iff (rst)
      clock_enable && wr && addr == `ADDR_CONTROL && wdata[`CTRL_LOAD_BIT] && !wdata[`CTRL_CLEAR_BIT]
      |=> state_reg.count == $past(state_reg.start))
      else $error("start count not loaded");
   chk_setup_bits: assert property (@(posedge clock) disable iff (rst)
      clock_enable && wr && addr == `ADDR_SETUP |=> count_up_mode == $past(wdata[`SETUP_DIR_BIT]))
      else $error("direction not taken");
   chk_sync_delay: assert property (@(posedge clock) disable iff (rst)
      clock_enable |=> state_reg.cnt_sync[0] == $past(count_pin))
      else $error("sync stage wrong");
   chk_gate_sync: assert property (@(posedge clock) disable iff (rst)
      clock_enable && state_reg.gate_sync[1] == state_reg.gate_sync[2]
      |=> state_reg.gate_level == $past(state_reg.gate_sync[2]))
      else $error("gate level not taken from agreeing stages");
   chk_read_count: assert property (@(posedge clock) disable iff (rst)
      read_count |=> rdata == $past(state_reg.count))
      else $error("count read wrong");
   chk_read_setup: assert property (@(posedge clock) disable iff (rst)
      read_setup |=> rdata == {30'h0000_0000, $past(state_reg.deb), $past(state_reg.dir)})
      else $error("setup read wrong");
   chk_read_idle: assert property (@(posedge clock) disable iff (rst)
      clock_enable && !rd |=> rdata == 32'h0000_0000)
      else $error("read data stood without a read");
   chk_freeze_hold: assert property (@(posedge clock) disable iff (rst)
      !clock_enable |=> $stable(state_reg))
      else $error("state moved with clock enable low");
endmodule // event_totalizer_counter

// >>> verification/pulse_source.sv
module pulse_source (
   input  wire logic clock,
   output logic      count_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // Signal source
   // ****************************************
   // A generator output, so the line idles low and is never released
   initial count_pin = 1'b0;
   task send(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge clock);
         count_pin <= 1'b1;
         repeat (half) @(posedge clock);
         count_pin <= 1'b0;
      end
   endtask
endmodule // pulse_source

// >>> verification/test_event_totalizer_counter.sv
module test_event_totalizer_counter;
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // Bench
   // ****************************************
   logic        clock;
   logic        rst;
   logic        ce;
   logic        count_pin;
   logic        gate;
   logic        wr;
   logic        rd;
   logic        up_mode;
   logic        deb_on;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [31:0] got;
   int          bad_count;
   int          cmp_count;
   event_totalizer_counter #(.DEBOUNCE_LIMIT(8)) dut (.clock(clock), .rst(rst), .clock_enable(ce),
      .count_pin(count_pin), .gating_control_line(gate), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .count_up_mode(up_mode), .debounce_on(deb_on));
   pulse_source src (.clock(clock), .count_pin(count_pin));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task rd_chk(input logic [3:0] a, input logic [31:0] e);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      got = rdata;
      chk(got, e);
      // Read data stand for one cycle only
      @(posedge clock);
      #1;
      chk(rdata, 32'h0000_0000);
   endtask
   // Mode outputs settle just after the edge that takes the write
   task mode_chk(input logic [1:0] e);
      #1;
      chk({30'h0000_0000, deb_on, up_mode}, {30'h0000_0000, e});
   endtask
   task set_gate(input logic v);
      @(posedge clock);
      gate <= v;
   endtask
   task set_ce(input logic v);
      @(posedge clock);
      ce <= v;
   endtask
   // Sync plus filter latency is short, so a fixed pause covers it
   task settle;
      repeat (30) @(posedge clock);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      rst <= 1'b1;
      ce <= 1'b1;
      wr <= 1'b0;
      rd <= 1'b0;
      addr <= 4'h0;
      wdata <= 32'h0000_0000;
      gate <= 1'b0;
      bad_count = 0;
      cmp_count = 0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      settle;
      rd_chk(4'h3, 32'h0000_0000);
      mode_chk(2'h1);
      src.send(3, 4);
      settle;
      rd_chk(4'h3, 32'h0000_0003);
      wr_reg(4'h0, 32'h0000_0001);
      rd_chk(4'h3, 32'h0000_0000);
      wr_reg(4'h1, 32'h0000_0000);
      mode_chk(2'h0);
      src.send(3, 4);
      settle;
      rd_chk(4'h3, 32'hFFFF_FFFD);
      wr_reg(4'h1, 32'h0000_0001);
      mode_chk(2'h1);
      wr_reg(4'h2, 32'hFFFF_FFFF);
      wr_reg(4'h0, 32'h0000_0002);
      rd_chk(4'h3, 32'hFFFF_FFFF);
      rd_chk(4'h2, 32'hFFFF_FFFF);
      rd_chk(4'h1, 32'h0000_0001);
      src.send(2, 4);
      settle;
      rd_chk(4'h3, 32'h0000_0001);
      set_gate(1'b1);
      settle;
      src.send(3, 4);
      settle;
      rd_chk(4'h3, 32'h0000_0001);
      set_gate(1'b0);
      wr_reg(4'h1, 32'h0000_0003);
      wr_reg(4'h0, 32'h0000_0001);
      mode_chk(2'h3);
      settle;
      src.send(5, 3);
      settle;
      rd_chk(4'h3, 32'h0000_0000);
      chk({31'h0000_0000, got <= 32'h0000_0001}, 32'h0000_0001);
      wr_reg(4'h0, 32'h0000_0001);
      src.send(2, 20);
      settle;
      rd_chk(4'h3, 32'h0000_0002);
      rd_chk(4'h1, 32'h0000_0003);
      wr_reg(4'h3, 32'h0000_0005);
      rd_chk(4'h3, 32'h0000_0002);
      rd_chk(4'h5, 32'h0000_0000);
      rd_chk(4'h0, 32'h0000_0000);
      // Clock enable low must freeze the count, ignore writes and miss pin activity
      set_ce(1'b0);
      wr_reg(4'h0, 32'h0000_0001);
      src.send(2, 4);
      set_ce(1'b1);
      settle;
      rd_chk(4'h3, 32'h0000_0002);
      // Reset in mid-run brings back the idle state
      @(posedge clock);
      rst <= 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      rd_chk(4'h3, 32'h0000_0000);
      mode_chk(2'h1);
      rd_chk(4'h2, 32'h0000_0000);
      settle;
      src.send(1, 4);
      settle;
      rd_chk(4'h3, 32'h0000_0001);
      wrap_up;
   end
   // The tests need about seven hundred cycles; the limit leaves ample room
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      wrap_up;
   end
endmodule // test_event_totalizer_counter
